// File: dsmf_ctrl_model.sv
// behavioural model of the attached controller's attention filtering
`timescale 1ns/1ns
`default_nettype none
module dsmf_ctrl_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [3:0] mask,
  input wire logic [3:0] avail,
  output logic [3:0] attn
);
  ////////////////////////////////////////////////////////////////
  // a suppressed subunit never raises an attention message
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      attn <= 4'h0;
    end else begin
      attn <= avail & ~mask;
    end
  end
endmodule
`default_nettype wire

// File: dsmf_irq.sv
// sticky event status, enable and interrupt line
`timescale 1ns/1ns
`default_nettype none
module dsmf_irq
  import dsmf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [EV_W-1:0] ev,
  input wire logic [EV_W-1:0] clr,
  input wire logic en_we,
  input wire logic [EV_W-1:0] en_wdata,
  output logic [EV_W-1:0] stat,
  output logic [EV_W-1:0] en,
  output logic irq
);
  typedef struct packed {
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] en;
  } dsmf_irq_st_t;
  dsmf_irq_st_t st_reg, st_next;
  // set wins over clear so no event is lost
  always_comb begin
    st_next = st_reg;
    st_next.stat = (st_reg.stat & ~clr) | ev;
    if (en_we) begin
      st_next.en = en_wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign stat = st_reg.stat;
  assign en = st_reg.en;
  assign irq = |(st_reg.stat & st_reg.en);
endmodule
`default_nettype wire

// File: dsmf_pkg.sv
// constants, types and behaviour list for the drive status message field builder
// Behaviour
// - the init failed flag in byte six is one after a failed initialization and zero after success.
// - the write lock error flag in byte six is set whenever a write is rejected by write locking.
// - byte seven carries the four-bit suppression mask, bit 0 for subunit 0 up to bit 3 for subunit 3.
// - the suppression mask follows the latest change-controller-flags command.
// - byte seven carries the state code: 0000 normal, 1000 diagnostic off-line, 1001 duplicate id.
// - while init failed is clear, byte eight holds the retry count of the previous operation.
// - while init failed is set, byte eight holds the drive error code instead.
// - bytes nine to fifteen carry drive-specific information defined by the drive.
// - the transmission error flag in byte six is set on a checksum or format error of a command.
package dsmf_pkg;
  // byte six bit positions
  localparam int unsigned B6_TX_ERR_BIT = 2;
  localparam int unsigned B6_INIT_FAIL_BIT = 1;
  localparam int unsigned B6_WLOCK_ERR_BIT = 0;
  // drive state codes
  localparam logic [3:0] STATE_NORMAL = 4'h0;
  localparam logic [3:0] STATE_DIAG_OFFLINE = 4'h8;
  localparam logic [3:0] STATE_DUP_ID = 4'h9;
  // apb offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS_LO = 8'h04;
  localparam logic [7:0] A_STATUS_HI = 8'h08;
  localparam logic [7:0] A_EXT_LO = 8'h0c;
  localparam logic [7:0] A_EXT_HI = 8'h10;
  localparam logic [7:0] A_IRQ_STAT = 8'h14;
  localparam logic [7:0] A_IRQ_EN = 8'h18;
  localparam logic [7:0] A_IRQ_CLR = 8'h1c;
  localparam logic [7:0] A_RETRY = 8'h20;
  localparam logic [7:0] A_ERR_CODE = 8'h24;
  // control register fields
  localparam int unsigned C_STATE_LSB = 0;
  localparam int unsigned C_INIT_DONE_BIT = 4;
  localparam int unsigned C_INIT_FAIL_BIT = 5;
  localparam int unsigned C_CLR_ERR_BIT = 6;
  // interrupt event bits
  localparam int unsigned EV_TX_ERR = 0;
  localparam int unsigned EV_WLOCK = 1;
  localparam int unsigned EV_INIT_FAIL = 2;
  localparam int unsigned EV_MASK_CHG = 3;
  localparam int unsigned EV_W = 4;
  // drive-level event inputs, one-cycle pulses on sys_clk except the flags_mask and op_retries data fields
  typedef struct packed {
    logic init_done;
    logic init_failed;
    logic wlock_reject;
    logic cmd_bad;
    logic flags_cmd;
    logic [3:0] flags_mask;
    logic op_done;
    logic [7:0] op_retries;
  } dsmf_event_t;
  // status bytes six to eight
  typedef struct packed {
    logic [7:0] byte6;
    logic [7:0] byte7;
    logic [7:0] byte8;
  } dsmf_status_t;
endpackage

// File: dsmf_top.sv
// drive status message fields: bytes six to fifteen behind an apb slave
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dsmf_top
  import dsmf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dsmf_pkg::dsmf_event_t ev_in,
  input wire logic [55:0] ext_info,
  output dsmf_pkg::dsmf_status_t status_out,
  output logic [55:0] ext_out,
  output logic irq
);
  import dsmf_pkg::*;

  typedef struct packed {
    logic init_fail;
    logic wlock_err;
    logic tx_err;
    logic [3:0] mask;
    logic [3:0] state;
    logic [7:0] retry;
    logic [7:0] err_code;
    logic [55:0] ext;
    dsmf_status_t status;
  } dsmf_st_t;

  dsmf_st_t st_reg, st_next;
  logic [EV_W-1:0] ev_vec, clr_vec, irq_stat, irq_en;
  logic wr_acc, rd_acc, en_we;

  // only defined codes pass; a reserved code leaves the state unchanged
  function automatic logic legal_state(input logic [3:0] c);
    return (c == STATE_NORMAL) || (c == STATE_DIAG_OFFLINE) || (c == STATE_DUP_ID);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // apb strobes; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign en_we = wr_acc && (paddr == A_IRQ_EN);
  assign clr_vec = (wr_acc && paddr == A_IRQ_CLR) ? pwdata[EV_W-1:0] : '0;

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    ev_vec = '0;
    // init outcome from the drive sequencer
    if (ev_in.init_failed) begin
      st_next.init_fail = 1'b1;
      ev_vec[EV_INIT_FAIL] = 1'b1;
    end else if (ev_in.init_done) begin
      st_next.init_fail = 1'b0;
    end
    // error flags are sticky until software clears them; a new event wins
    if (wr_acc && paddr == A_CTRL && pwdata[C_CLR_ERR_BIT]) begin
      st_next.wlock_err = 1'b0;
      st_next.tx_err = 1'b0;
    end
    if (ev_in.wlock_reject) begin
      st_next.wlock_err = 1'b1;
      ev_vec[EV_WLOCK] = 1'b1;
    end
    if (ev_in.cmd_bad) begin
      st_next.tx_err = 1'b1;
      ev_vec[EV_TX_ERR] = 1'b1;
    end
    // latest change-controller-flags command replaces the mask
    if (ev_in.flags_cmd) begin
      st_next.mask = ev_in.flags_mask;
      ev_vec[EV_MASK_CHG] = 1'b1;
    end
    if (ev_in.op_done) begin
      st_next.retry = ev_in.op_retries;
    end
    // software-driven state code and init outcome (diagnostic use)
    if (wr_acc && paddr == A_CTRL) begin
      if (legal_state(pwdata[C_STATE_LSB +: 4])) begin
        st_next.state = pwdata[C_STATE_LSB +: 4];
      end
      if (pwdata[C_INIT_FAIL_BIT]) begin
        st_next.init_fail = 1'b1;
        ev_vec[EV_INIT_FAIL] = 1'b1;
      end else if (pwdata[C_INIT_DONE_BIT] && !ev_in.init_failed) begin
        // a drive failure report beats a software success in the same cycle
        st_next.init_fail = 1'b0;
      end
    end
    if (wr_acc && paddr == A_ERR_CODE) begin
      st_next.err_code = pwdata[7:0];
    end
    // drive-defined extended bytes sampled every cycle
    st_next.ext = ext_info;
    // status bytes built from the next field values so they land together
    st_next.status.byte6 = '0;
    st_next.status.byte6[B6_TX_ERR_BIT] = st_next.tx_err;
    st_next.status.byte6[B6_INIT_FAIL_BIT] = st_next.init_fail;
    st_next.status.byte6[B6_WLOCK_ERR_BIT] = st_next.wlock_err;
    st_next.status.byte7 = {st_next.state, st_next.mask};
    // byte eight changes meaning with the init failure flag
    st_next.status.byte8 = st_next.init_fail ? st_next.err_code : st_next.retry;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // read data is combinational from live state so it is valid in the access phase
  always_comb begin
    prdata = 32'h0;
    if (rd_acc) begin
      unique case (paddr)
        A_CTRL: prdata = {26'h0, st_reg.init_fail, 1'b0, st_reg.state};
        A_STATUS_LO: prdata = {8'h00, st_reg.status};
        A_STATUS_HI: prdata = {24'h0, st_reg.status.byte8};
        A_EXT_LO: prdata = st_reg.ext[31:0];
        A_EXT_HI: prdata = {8'h00, st_reg.ext[55:32]};
        A_IRQ_STAT: prdata = {28'h0, irq_stat};
        A_IRQ_EN: prdata = {28'h0, irq_en};
        A_RETRY: prdata = {24'h0, st_reg.retry};
        A_ERR_CODE: prdata = {24'h0, st_reg.err_code};
        default: prdata = 32'h0;
      endcase
    end
  end

  assign status_out = st_reg.status;
  assign ext_out = st_reg.ext;

  dsmf_irq u_irq (
    .sys_clk(sys_clk),
    .reset(reset),
    .ev(ev_vec),
    .clr(clr_vec),
    .en_we(en_we),
    .en_wdata(pwdata[EV_W-1:0]),
    .stat(irq_stat),
    .en(irq_en),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////
  // assertions
  property p_init_set;
    @(posedge sys_clk) disable iff (reset)
      ev_in.init_failed |=> status_out.byte6[B6_INIT_FAIL_BIT];
  endproperty
  a_init_set: assert property (p_init_set) else $error("init fail flag not set");

  property p_init_clr;
    @(posedge sys_clk) disable iff (reset)
      (ev_in.init_done && !ev_in.init_failed && !wr_acc) |=> !status_out.byte6[B6_INIT_FAIL_BIT];
  endproperty
  a_init_clr: assert property (p_init_clr) else $error("init fail flag not cleared");

  property p_wlock;
    @(posedge sys_clk) disable iff (reset)
      ev_in.wlock_reject |=> status_out.byte6[B6_WLOCK_ERR_BIT] && irq_stat[EV_WLOCK];
  endproperty
  a_wlock: assert property (p_wlock) else $error("write lock error lost");

  property p_mask;
    @(posedge sys_clk) disable iff (reset)
      ev_in.flags_cmd |=> status_out.byte7[3:0] == $past(ev_in.flags_mask);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not from last flags command");

  property p_mask_hold;
    @(posedge sys_clk) disable iff (reset)
      !ev_in.flags_cmd |=> $stable(status_out.byte7[3:0]);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without command");

  property p_state_legal;
    @(posedge sys_clk) disable iff (reset)
      legal_state(status_out.byte7[7:4]);
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("reserved state code");

  property p_state_reserved;
    @(posedge sys_clk) disable iff (reset)
      (wr_acc && paddr == A_CTRL && !legal_state(pwdata[3:0])) |=> $stable(status_out.byte7[7:4]);
  endproperty
  a_state_reserved: assert property (p_state_reserved) else $error("reserved code accepted");

  property p_retry;
    @(posedge sys_clk) disable iff (reset)
      (ev_in.op_done && !st_next.init_fail) |=> status_out.byte8 == $past(ev_in.op_retries);
  endproperty
  a_retry: assert property (p_retry) else $error("retry count wrong");

  property p_errcode;
    @(posedge sys_clk) disable iff (reset)
      status_out.byte6[B6_INIT_FAIL_BIT] |-> status_out.byte8 == st_reg.err_code;
  endproperty
  a_errcode: assert property (p_errcode) else $error("byte eight not error code");

  property p_ext;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |=> ext_out == $past(ext_info);
  endproperty
  a_ext: assert property (p_ext) else $error("extended bytes wrong");

  property p_txerr;
    @(posedge sys_clk) disable iff (reset)
      ev_in.cmd_bad |=> status_out.byte6[B6_TX_ERR_BIT] && irq_stat[EV_TX_ERR];
  endproperty
  a_txerr: assert property (p_txerr) else $error("transmission error not flagged");

  c_init_fail: cover property (@(posedge sys_clk) disable iff (reset)
    ev_in.init_failed ##1 status_out.byte6[B6_INIT_FAIL_BIT]);
  c_dup_id: cover property (@(posedge sys_clk) disable iff (reset)
    status_out.byte7[7:4] == STATE_DUP_ID);
  c_irq: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq));
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the drive status message field builder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dsmf_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  dsmf_event_t ev_in = '0;
  logic [55:0] ext_info = 56'h0;
  dsmf_status_t status_out;
  logic [55:0] ext_out;
  logic irq;
  logic [3:0] avail = 4'hf;
  logic [3:0] attn;
  logic [31:0] q;
  int error_cnt = 0;
  int total_checks = 0;
  logic [3:0] masks [3] = '{4'h1, 4'h8, 4'ha};
  logic [3:0] codes [5] = '{4'h8, 4'h0, 4'h9, 4'h3, 4'h0};
  logic [3:0] seen [5] = '{4'h8, 4'h0, 4'h9, 4'h9, 4'h0};

  always #20 sys_clk = ~sys_clk;

  dsmf_top u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .ev_in(ev_in), .ext_info(ext_info), .status_out(status_out),
    .ext_out(ext_out), .irq(irq));
  dsmf_ctrl_model u_ctrl (.sys_clk(sys_clk), .reset(reset), .mask(status_out.byte7[3:0]),
    .avail(avail), .attn(attn));

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      stop_test();
    end
  endtask

  // one-cycle event pulse, checked after the capturing edge
  task automatic pulse(input dsmf_event_t e);
    @(posedge sys_clk);
    ev_in <= e;
    @(posedge sys_clk);
    ev_in <= '0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_wlock();
    dsmf_event_t e = '0;
    apb(1'b1, A_IRQ_EN, 32'hf);
    e.wlock_reject = 1'b1;
    pulse(e);
    chk("byte6", 8'h01, status_out.byte6);
    @(posedge sys_clk);
    #1;
    chk("irq", 1'b1, irq);
    apb(1'b1, A_IRQ_EN, 32'h0);
    #1;
    chk("irq masked", 1'b0, irq);
    apb(1'b1, A_IRQ_EN, 32'hf);
    apb(1'b0, A_IRQ_EN, 32'h0);
    chk("irq_en", 32'hf, q);
    apb(1'b0, A_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h2, q);
    apb(1'b1, A_IRQ_CLR, 32'h2);
    #1;
    chk("irq clr", 1'b0, irq);
    e = '0;
    e.cmd_bad = 1'b1;
    pulse(e);
    chk("byte6 tx", 8'h05, status_out.byte6);
    apb(1'b1, A_CTRL, 32'h40);
    #1;
    chk("byte6 clr", 8'h00, status_out.byte6);
  endtask

  task automatic t_mask();
    dsmf_event_t e = '0;
    e.flags_cmd = 1'b1;
    foreach (masks[i]) begin
      e.flags_mask = masks[i];
      pulse(e);
      chk("mask", masks[i], status_out.byte7[3:0]);
      @(posedge sys_clk);
      #1;
      chk("attn", avail & ~masks[i], attn);
    end
  endtask

  task automatic t_state();
    foreach (codes[i]) begin
      apb(1'b1, A_CTRL, {28'h0, codes[i]});
      #1;
      chk("state", seen[i], status_out.byte7[7:4]);
    end
  endtask

  task automatic t_byte8();
    dsmf_event_t e = '0;
    e.op_done = 1'b1;
    e.op_retries = 8'h0e;
    pulse(e);
    chk("retries", 8'h0e, status_out.byte8);
    apb(1'b1, A_ERR_CODE, 32'h5a);
    e = '0;
    e.init_failed = 1'b1;
    pulse(e);
    chk("df", 8'h02, status_out.byte6);
    chk("errcode", 8'h5a, status_out.byte8);
    apb(1'b0, A_STATUS_LO, 32'h0);
    chk("status lo", 32'h00020a5a, q);
    apb(1'b0, A_STATUS_HI, 32'h0);
    chk("status hi", 32'h5a, q);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl df", 32'h20, q);
    e = '0;
    e.init_done = 1'b1;
    pulse(e);
    chk("df ok", 8'h00, status_out.byte6);
    chk("retries", 8'h0e, status_out.byte8);
    apb(1'b1, A_CTRL, 32'h20);
    #1;
    chk("df sw", 8'h02, status_out.byte6);
    apb(1'b1, A_CTRL, 32'h10);
    #1;
    chk("df sw ok", 8'h00, status_out.byte6);
    apb(1'b0, A_RETRY, 32'h0);
    chk("retry reg", 32'h0e, q);
  endtask

  task automatic t_ext();
    @(posedge sys_clk);
    ext_info <= 56'h0f1e2d3c4b5a69;
    @(posedge sys_clk);
    #1;
    chk("ext_out", 56'h0f1e2d3c4b5a69, ext_out);
    apb(1'b0, A_EXT_LO, 32'h0);
    chk("ext lo", 32'h3c4b5a69, q);
    apb(1'b0, A_EXT_HI, 32'h0);
    chk("ext hi", 32'h000f1e2d, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("status", 24'h0, status_out);
    chk("irq", 1'b0, irq);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl", 32'h0, q);
    t_wlock();
    t_mask();
    t_state();
    t_byte8();
    t_ext();
    stop_test();
  end
endmodule
`default_nettype wire
